// File: logic/pzd_handler.v
// Cyclic process-data handler: command decode, status return, slot transfers, LEDs
//
// The implementer's own choices: the Avalon-MM register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "pzd_map.vh"

module pzd_handler #(
    parameter [31:0] BLINK_CYCLES = `BLINK_MS * `CLK_KHZ
) (
    input wire i_clk, // System clock, 100 MHz
    input wire i_reset, // Asynchronous reset, active high
    input wire [6:0] i_avs_address, // Avalon word address
    input wire i_avs_read, // Avalon read
    input wire i_avs_write, // Avalon write
    input wire [31:0] i_avs_writedata, // Avalon write data
    output reg [31:0] o_avs_readdata, // Avalon read data
    output reg o_avs_waitrequest, // Avalon waitrequest
    input wire i_rx_valid, // Master word strobe
    input wire [15:0] i_rx_data, // Master word
    input wire i_rx_last, // Last word of frame
    input wire i_rx_good, // Frame check passed, with last
    input wire i_tx_req, // Start of returned frame
    output reg o_tx_valid, // Returned word strobe
    output reg [15:0] o_tx_data, // Returned word
    output reg o_tx_last, // Last returned word
    output reg o_par_req, // Parameter access request
    output reg o_par_we, // Parameter access is a write
    output reg [15:0] o_par_addr, // Parameter address
    output reg [15:0] o_par_wdata, // Parameter write value
    input wire i_par_ack, // Parameter access done
    input wire [15:0] i_par_rdata, // Parameter read value
    input wire i_drv_running, // Drive running
    input wire i_drv_forward, // Drive running forward
    input wire i_drv_reverse, // Drive running reverse
    input wire i_drv_fault, // Drive faulted
    input wire i_drv_coasting, // Drive coasting to stop
    input wire i_drv_comm_ok, // Drive communication healthy
    input wire i_freq_reached, // Target frequency reached
    input wire i_torque_active, // Torque control active
    input wire [15:0] i_run_freq, // Running frequency, 0.01 Hz
    input wire [15:0] i_max_freq, // Maximum frequency, 0.01 Hz
    input wire i_master_found, // Master station found
    input wire i_config_err, // Configuration error
    input wire i_master_lost, // Master lost
    input wire i_mac_bad, // MAC address invalid
    output reg o_cmd_ramp_stop, // Ramp to stop command
    output reg o_cmd_coast_stop, // Coast to stop command
    output reg o_cmd_forward, // Forward run command
    output reg o_cmd_reverse, // Reverse run command
    output reg o_cmd_quick_stop, // Quick stop request
    output reg o_cmd_torque_mode, // Torque control selected
    output reg o_cmd_fault_reset, // Fault reset pulse
    output reg o_cmd_enabled, // Command word enabled
    output reg [15:0] o_target_freq, // Target frequency, 0.01 Hz
    output reg o_target_valid, // Target frequency applied
    output reg o_ctrl_led_green, // Controller link LED green
    output reg o_ctrl_led_yellow, // Controller link LED yellow
    output reg o_ctrl_led_red, // Controller link LED red
    output reg o_drv_led_green, // Drive link LED green
    output reg o_drv_led_yellow, // Drive link LED yellow
    output reg o_drv_led_red // Drive link LED red
);

    localparam [2:0] S_INIT = 3'h0;
    localparam [2:0] S_IDLE = 3'h1;
    localparam [2:0] S_OVR = 3'h2;
    localparam [2:0] S_BASE = 3'h3;
    localparam [2:0] S_ADDR = 3'h4;
    localparam [2:0] S_WAIT = 3'h5;
    localparam [1:0] B_IDLE = 2'h0;
    localparam [1:0] B_MEM = 2'h1;
    localparam [1:0] B_ACK = 2'h2;

    reg [15:0] format_param;
    reg freq_src_comm;
    reg [15:0] frame_count;
    reg [15:0] cmd_word;
    reg [3:0] rx_count;
    reg [15:0] rx_cw;
    reg [15:0] rx_sp;
    reg [15:0] rx_slot [0:9];
    reg [15:0] wr_val [0:9];
    reg [15:0] rd_val [0:9];
    reg commit_pending;
    reg [2:0] seq_state;
    reg [4:0] seq_slot;
    reg [5:0] init_idx;
    reg [15:0] ovr_addr;
    reg [1:0] bus_state;
    reg [3:0] tx_idx;
    reg tx_busy;
    reg [31:0] blink_cnt;
    reg blink;
    reg [15:0] sp_mag;
    reg [31:0] sp_scaled;
    reg [15:0] next_target;
    reg [15:0] status_word;
    reg [5:0] mem_addr;
    reg mem_we;
    reg [15:0] mem_wdata;
    wire [15:0] mem_rdata;
    wire [2:0] grp = i_avs_address[6:4];
    wire slot_hit = (grp >= `GRP_WR_BASE) && (grp <= `GRP_RD_OVR) && (i_avs_address[3:0] < `SLOT_COUNT);
    wire [5:0] bus_idx = {grp[1:0] - 2'h1, i_avs_address[3:0]};
    wire bus_req = i_avs_read | i_avs_write;
    wire seq_rd = seq_slot >= 5'h0A;
    wire [3:0] seq_sub = seq_rd ? seq_slot[3:0] - 4'hA : seq_slot[3:0];
    integer k;

    slot_addr_mem u_mem (
        .i_clk(i_clk),
        .i_we(mem_we),
        .i_addr(mem_addr),
        .i_wdata(mem_wdata),
        .o_rdata(mem_rdata)
    );

    // Memory port: fill after reset, sequencer lookups, bus accesses
    always @* begin
        mem_we = 1'b0;
        mem_wdata = 16'h0000;
        mem_addr = bus_idx;
        if (seq_state == S_INIT) begin
            mem_we = 1'b1;
            mem_addr = init_idx;
            mem_wdata = init_idx[5] ? `SLOT_UNASSIGNED : 16'h0000;
        end else if (seq_state == S_OVR) begin
            mem_addr = {1'b1, seq_rd, seq_sub};
        end else if (seq_state == S_BASE) begin
            mem_addr = {1'b0, seq_rd, seq_sub};
        end else if (bus_state == B_ACK && i_avs_write && slot_hit) begin
            mem_we = 1'b1;
            mem_wdata = i_avs_writedata[15:0];
        end
    end

    // Setpoint magnitude and scaling
    always @* begin
        sp_mag = rx_sp[15] ? 16'h0000 - rx_sp : rx_sp;
        sp_scaled = 32'h0000_0000;
        if (format_param[0] == 1'b0) begin
            if (sp_mag > `PCT_FULL) begin
                sp_scaled = {16'h0000, i_max_freq};
            end else begin
                sp_scaled = ({16'h0000, sp_mag} * {16'h0000, i_max_freq}) / {16'h0000, `PCT_FULL};
            end
        end else begin
            sp_scaled = {16'h0000, (sp_mag > i_max_freq) ? i_max_freq : sp_mag};
        end
        next_target = sp_scaled[15:0];
    end

    // Returned status word
    always @* begin
        status_word = 16'h0000;
        status_word[0] = i_drv_running;
        status_word[1] = i_drv_forward;
        status_word[2] = i_drv_reverse;
        status_word[3] = ~i_drv_fault;
        status_word[4] = i_drv_coasting;
        status_word[5] = ~i_drv_comm_ok;
        status_word[6] = i_freq_reached;
        status_word[7] = i_torque_active;
    end

    // Master frame reception and commit
    always @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            rx_count <= 4'h0;
            rx_cw <= 16'h0000;
            rx_sp <= 16'h0000;
            for (k = 0; k < 10; k = k + 1) begin
                rx_slot[k] <= 16'h0000;
            end
        end else if (i_rx_valid) begin
            rx_count <= i_rx_last ? 4'h0 : rx_count + 4'h1;
            if (rx_count == 4'h0) begin
                rx_cw <= i_rx_data;
            end else if (rx_count == 4'h1) begin
                rx_sp <= i_rx_data;
            end else if (rx_count < `FRAME_WORDS) begin
                rx_slot[rx_count - 4'h2] <= i_rx_data;
            end
        end
    end

    wire frame_ok = i_rx_valid && i_rx_last && i_rx_good && (rx_count == `FRAME_WORDS - 4'h1);
    reg commit;

    always @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            commit <= 1'b0;
        end else begin
            commit <= frame_ok;
        end
    end

    // Command decode, applied one cycle after a good frame
    always @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            cmd_word <= 16'h0000;
            frame_count <= 16'h0000;
            o_cmd_ramp_stop <= 1'b0;
            o_cmd_coast_stop <= 1'b0;
            o_cmd_forward <= 1'b0;
            o_cmd_reverse <= 1'b0;
            o_cmd_quick_stop <= 1'b0;
            o_cmd_torque_mode <= 1'b0;
            o_cmd_fault_reset <= 1'b0;
            o_cmd_enabled <= 1'b0;
            o_target_freq <= 16'h0000;
            o_target_valid <= 1'b0;
            for (k = 0; k < 10; k = k + 1) begin
                wr_val[k] <= 16'h0000;
            end
        end else begin
            o_cmd_fault_reset <= 1'b0;
            o_target_valid <= freq_src_comm;
            if (commit) begin
                cmd_word <= {8'h00, rx_cw[7:0]};
                frame_count <= frame_count + 16'h0001;
                o_cmd_enabled <= rx_cw[`CW_ENABLE];
                o_cmd_ramp_stop <= rx_cw[`CW_ENABLE] & rx_cw[`CW_RAMP_STOP];
                o_cmd_coast_stop <= rx_cw[`CW_ENABLE] & rx_cw[`CW_COAST_STOP];
                o_cmd_forward <= rx_cw[`CW_ENABLE] & rx_cw[`CW_FWD];
                o_cmd_reverse <= rx_cw[`CW_ENABLE] & rx_cw[`CW_REV];
                o_cmd_quick_stop <= rx_cw[`CW_QUICK_STOP];
                o_cmd_torque_mode <= rx_cw[`CW_TORQUE];
                o_cmd_fault_reset <= rx_cw[`CW_ENABLE] & rx_cw[`CW_FAULT_RESET];
                if (freq_src_comm) begin
                    o_target_freq <= next_target;
                end
                for (k = 0; k < 10; k = k + 1) begin
                    wr_val[k] <= rx_slot[k];
                end
            end
        end
    end

    // Slot sequencer: memory fill, then ten writes and ten reads per frame
    always @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            seq_state <= S_INIT;
            seq_slot <= 5'h00;
            init_idx <= 6'h00;
            ovr_addr <= 16'h0000;
            commit_pending <= 1'b0;
            o_par_req <= 1'b0;
            o_par_we <= 1'b0;
            o_par_addr <= 16'h0000;
            o_par_wdata <= 16'h0000;
            for (k = 0; k < 10; k = k + 1) begin
                rd_val[k] <= 16'h0000;
            end
        end else begin
            if (commit) begin
                commit_pending <= 1'b1;
            end
            case (seq_state)
                S_INIT: begin
                    init_idx <= init_idx + 6'h01;
                    if (init_idx == 6'h3F) begin
                        seq_state <= S_IDLE;
                    end
                end
                S_IDLE: begin
                    if (commit_pending && bus_state == B_IDLE) begin
                        commit_pending <= commit;
                        seq_slot <= 5'h00;
                        seq_state <= S_OVR;
                    end
                end
                S_OVR: begin
                    seq_state <= S_BASE;
                end
                S_BASE: begin
                    ovr_addr <= mem_rdata;
                    seq_state <= S_ADDR;
                end
                S_ADDR: begin
                    o_par_req <= 1'b1;
                    o_par_we <= ~seq_rd;
                    o_par_addr <= (ovr_addr != `SLOT_UNASSIGNED) ? ovr_addr : mem_rdata;
                    o_par_wdata <= seq_rd ? 16'h0000 : wr_val[seq_sub];
                    seq_state <= S_WAIT;
                end
                S_WAIT: begin
                    if (i_par_ack) begin
                        o_par_req <= 1'b0;
                        if (seq_rd) begin
                            rd_val[seq_sub] <= i_par_rdata;
                        end
                        if (seq_slot == 5'h13) begin
                            seq_state <= S_IDLE;
                        end else begin
                            seq_slot <= seq_slot + 5'h01;
                            seq_state <= S_OVR;
                        end
                    end
                end
                default: begin
                    seq_state <= S_IDLE;
                end
            endcase
        end
    end

    // Returned frame: status, frequency, ten read slot values
    always @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            tx_busy <= 1'b0;
            tx_idx <= 4'h0;
            o_tx_valid <= 1'b0;
            o_tx_data <= 16'h0000;
            o_tx_last <= 1'b0;
        end else begin
            o_tx_valid <= tx_busy;
            o_tx_last <= tx_busy && (tx_idx == `FRAME_WORDS - 4'h1);
            if (tx_busy) begin
                if (tx_idx == 4'h0) begin
                    o_tx_data <= status_word;
                end else if (tx_idx == 4'h1) begin
                    o_tx_data <= i_run_freq;
                end else begin
                    o_tx_data <= rd_val[tx_idx - 4'h2];
                end
                tx_idx <= tx_idx + 4'h1;
                if (tx_idx == `FRAME_WORDS - 4'h1) begin
                    tx_busy <= 1'b0;
                    tx_idx <= 4'h0;
                end
            end else if (i_tx_req) begin
                tx_busy <= 1'b1;
            end
        end
    end

    // Avalon-MM slave
    always @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            bus_state <= B_IDLE;
            o_avs_waitrequest <= 1'b1;
            o_avs_readdata <= 32'h0000_0000;
            format_param <= `FORMAT_RESET;
            freq_src_comm <= `CTRL_RESET;
        end else begin
            case (bus_state)
                B_IDLE: begin
                    if (bus_req && seq_state == S_IDLE && !commit_pending) begin
                        bus_state <= B_MEM;
                    end
                end
                B_MEM: begin
                    o_avs_waitrequest <= 1'b0;
                    bus_state <= B_ACK;
                end
                B_ACK: begin
                    o_avs_waitrequest <= 1'b1;
                    bus_state <= B_IDLE;
                    if (i_avs_write && i_avs_address == `REG_FORMAT) begin
                        format_param <= i_avs_writedata[15:0];
                    end
                    if (i_avs_write && i_avs_address == `REG_CTRL) begin
                        freq_src_comm <= i_avs_writedata[0];
                    end
                end
                default: begin
                    bus_state <= B_IDLE;
                    o_avs_waitrequest <= 1'b1;
                end
            endcase
            if (bus_state == B_MEM) begin
                o_avs_readdata <= slot_hit ? {16'h0000, mem_rdata} : 32'h0000_0000;
            end
            if (bus_state == B_MEM && !slot_hit) begin
                case (i_avs_address)
                    `REG_FORMAT: o_avs_readdata <= {16'h0000, format_param};
                    `REG_CTRL: o_avs_readdata <= {31'h0000_0000, freq_src_comm};
                    `REG_STATUS: o_avs_readdata <= {16'h0000, status_word};
                    `REG_FREQ: o_avs_readdata <= {o_target_freq, i_run_freq};
                    `REG_FRAMES: o_avs_readdata <= {16'h0000, frame_count};
                    `REG_CMDWORD: o_avs_readdata <= {16'h0000, cmd_word};
                    default: o_avs_readdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Link indicators
    always @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            blink_cnt <= 32'h0000_0000;
            blink <= 1'b0;
            o_ctrl_led_green <= 1'b0;
            o_ctrl_led_yellow <= 1'b0;
            o_ctrl_led_red <= 1'b0;
            o_drv_led_green <= 1'b0;
            o_drv_led_yellow <= 1'b0;
            o_drv_led_red <= 1'b0;
        end else begin
            if (blink_cnt >= BLINK_CYCLES - 32'h1) begin
                blink_cnt <= 32'h0000_0000;
                blink <= ~blink;
            end else begin
                blink_cnt <= blink_cnt + 32'h1;
            end
            o_ctrl_led_red <= i_master_lost;
            o_ctrl_led_yellow <= ~i_master_lost & i_config_err;
            o_ctrl_led_green <= ~i_master_lost & ~i_config_err & (i_master_found | blink);
            o_drv_led_red <= ~i_drv_comm_ok;
            o_drv_led_yellow <= i_drv_comm_ok & (i_mac_bad | (i_drv_fault & blink));
            o_drv_led_green <= i_drv_comm_ok & ~i_mac_bad & ~i_drv_fault;
        end
    end

endmodule

`default_nettype wire

// File: logic/pzd_map.vh
// Constants for the cyclic process-data handler: offsets, fields, resets, timing
`ifndef PZD_MAP_VH
`define PZD_MAP_VH

// Clock rate in kHz and blink half period in ms
`define CLK_KHZ 100000
`define BLINK_MS 250

// Frame shape
`define FRAME_WORDS 4'hC
`define SLOT_COUNT 4'hA
`define SLOT_UNASSIGNED 16'hFFFF

// Register word offsets and slot group numbers (address bits 6:4)
`define REG_FORMAT 7'h00
`define REG_CTRL 7'h01
`define REG_STATUS 7'h02
`define REG_FREQ 7'h03
`define REG_FRAMES 7'h04
`define REG_CMDWORD 7'h05
`define GRP_WR_BASE 3'h1
`define GRP_RD_BASE 3'h2
`define GRP_WR_OVR 3'h3
`define GRP_RD_OVR 3'h4

// Reset values
`define FORMAT_RESET 16'h0000
`define CTRL_RESET 1'h0

// Control word bit positions
`define CW_RAMP_STOP 0
`define CW_COAST_STOP 1
`define CW_FWD 2
`define CW_REV 3
`define CW_QUICK_STOP 4
`define CW_TORQUE 5
`define CW_FAULT_RESET 6
`define CW_ENABLE 7

// Setpoint scaling
`define PCT_FULL 16'h2710

`endif

// File: logic/slot_addr_mem.v
// Slot address memory: 64 words of 16 bits with registered read data
`timescale 1ns/1ps
`default_nettype none

module slot_addr_mem (
    input wire i_clk, // System clock
    input wire i_we, // Write strobe
    input wire [5:0] i_addr, // Word address
    input wire [15:0] i_wdata, // Write data
    output reg [15:0] o_rdata // Read data, one cycle after address
);

    reg [15:0] mem [0:63];

    always @(posedge i_clk) begin
        if (i_we) begin
            mem[i_addr] <= i_wdata;
        end
        o_rdata <= mem[i_addr];
    end

endmodule

`default_nettype wire

// File: testbench/master_model.sv
// Far-side model: master frame source and drive parameter responder, reads return the inverted address
`timescale 1ns/1ps
`default_nettype none
module master_model (
    input wire logic i_clk, input wire logic i_go, input wire logic i_good, // Clock, start, frame check
    input wire logic [15:0] i_words [12], // Frame words
    input wire logic i_par_req, input wire logic [15:0] i_par_addr, // Parameter request
    output logic o_valid, output logic [15:0] o_data, output logic o_last, output logic o_good, // Frame out
    output logic o_par_ack, output logic [15:0] o_par_rdata // Parameter answer
);
    int idx = 12;
    initial begin
        {o_valid, o_last, o_good, o_par_ack} = '0;
        o_data = '0;
        o_par_rdata = '0;
    end
    always @(posedge i_clk) begin
        if (i_go) idx <= 0;
        else if (idx < 12) idx <= idx + 1;
        if (!i_go && idx < 12) begin
            o_valid <= 1'b1;
            o_data <= i_words[idx];
            o_last <= idx == 11;
            o_good <= idx == 11 && i_good;
        end else begin
            o_valid <= 1'b0;
            o_data <= ~o_data;
            o_last <= 1'b0;
            o_good <= 1'b0;
        end
        o_par_ack <= i_par_req && !o_par_ack;
        o_par_rdata <= i_par_req ? ~i_par_addr : ~o_par_rdata;
    end
endmodule
`default_nettype wire

// File: testbench/pzd_checks_asserts.sv
// Port assertions for the process-data handler
`timescale 1ns/1ps
`default_nettype none
module pzd_checks (
    input wire i_clk, input wire i_reset, input wire o_avs_waitrequest, input wire i_tx_req, // Clock, bus
    input wire o_tx_valid, input wire o_tx_last, input wire o_par_req, input wire i_par_ack, // Return, params
    input wire [15:0] o_par_addr, input wire o_cmd_fault_reset, input wire o_cmd_enabled, // Commands
    input wire o_cmd_forward, input wire o_cmd_reverse, input wire i_master_lost, input wire i_config_err, // Runs
    input wire i_drv_comm_ok, input wire o_ctrl_led_red, input wire o_ctrl_led_yellow, input wire o_drv_led_red // LEDs
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_reset);
    a_wait_pulse: assert property (!o_avs_waitrequest |=> o_avs_waitrequest) else $error("waitrequest held low");
    a_tx_start: assert property ($rose(i_tx_req) |-> ##[1:2] o_tx_valid) else $error("return frame late");
    a_tx_len: assert property (o_tx_last |-> $past(o_tx_valid, 11) && !$past(o_tx_last)) else $error("frame length");
    a_tx_end: assert property (o_tx_last |=> !o_tx_valid) else $error("return frame too long");
    a_reset_pulse: assert property (o_cmd_fault_reset |=> !o_cmd_fault_reset) else $error("reset pulse long");
    a_reset_gate: assert property (o_cmd_fault_reset |-> o_cmd_enabled) else $error("reset without enable");
    a_run_gate: assert property (o_cmd_forward || o_cmd_reverse |-> o_cmd_enabled) else $error("run ungated");
    a_par_hold: assert property (o_par_req && !i_par_ack |=> o_par_req && $stable(o_par_addr))
        else $error("parameter request dropped");
    a_ctrl_red: assert property (i_master_lost [*3] |-> o_ctrl_led_red) else $error("link red missing");
    a_ctrl_yel: assert property ((i_config_err && !i_master_lost) [*3] |-> o_ctrl_led_yellow)
        else $error("link yellow missing");
    a_drv_red: assert property (!i_drv_comm_ok [*3] |-> o_drv_led_red) else $error("drive red missing");
endmodule
bind pzd_handler pzd_checks chk (.*);
`default_nettype wire

// File: testbench/tb.sv
// Self-checking bench for the process-data handler
`timescale 1ns/1ps
`default_nettype none
`include "pzd_map.vh"
module tb;
    logic i_clk, i_reset, i_avs_read, i_avs_write, i_rx_valid, i_rx_last, i_rx_good, i_tx_req, i_par_ack;
    logic i_drv_running, i_drv_forward, i_drv_reverse, i_drv_fault, i_drv_coasting, i_drv_comm_ok;
    logic i_freq_reached, i_torque_active, i_master_found, i_config_err, i_master_lost, i_mac_bad, go, good;
    logic [6:0] i_avs_address;
    logic [31:0] i_avs_writedata, o_avs_readdata, q;
    logic [15:0] i_rx_data, i_par_rdata, i_run_freq, i_max_freq, o_tx_data, o_par_addr, o_par_wdata, o_target_freq;
    logic o_avs_waitrequest, o_tx_valid, o_tx_last, o_par_req, o_par_we, o_cmd_ramp_stop, o_cmd_coast_stop;
    logic o_cmd_forward, o_cmd_reverse, o_cmd_quick_stop, o_cmd_torque_mode, o_cmd_fault_reset, o_cmd_enabled;
    logic o_target_valid, o_ctrl_led_green, o_ctrl_led_yellow, o_ctrl_led_red, o_drv_led_green, o_drv_led_yellow;
    logic o_drv_led_red;
    logic [15:0] words [12];
    logic [31:0] wlog[$];
    logic [15:0] txq[$];
    int miscompares = 0, n_checks = 0, cyc = 0;
    pzd_handler #(.BLINK_CYCLES(32'h4)) dut (.*);
    master_model far (.i_clk(i_clk), .i_go(go), .i_good(good), .i_words(words), .i_par_req(o_par_req),
        .i_par_addr(o_par_addr), .o_valid(i_rx_valid), .o_data(i_rx_data), .o_last(i_rx_last), .o_good(i_rx_good),
        .o_par_ack(i_par_ack), .o_par_rdata(i_par_rdata));
    initial begin
        i_clk = 0;
        forever #5 i_clk = ~i_clk;
    end
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (o_tx_valid) txq.push_back(o_tx_data);
        if (o_par_req && i_par_ack && o_par_we) wlog.push_back({o_par_addr, o_par_wdata});
        if (cyc == 20000) begin
            miscompares++;
            conclude();
        end
    end
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic bus(input logic w, input logic [6:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_avs_address <= a;
        i_avs_writedata <= d;
        i_avs_write <= w;
        i_avs_read <= !w;
        do @(posedge i_clk); while (o_avs_waitrequest !== 1'b0);
        q = o_avs_readdata;
        i_avs_write <= 1'b0;
        i_avs_read <= 1'b0;
    endtask
    task automatic frame(input logic [15:0] cw, input logic [15:0] sp, input logic g);
        @(posedge i_clk);
        words[0] <= cw;
        words[1] <= sp;
        good <= g;
        go <= 1'b1;
        @(posedge i_clk);
        go <= 1'b0;
        repeat (18) @(posedge i_clk);
    endtask
    task automatic t_regs();
        bus(1, `REG_CTRL, 32'h1);
        bus(0, `REG_CTRL, 32'h0);
        check("ctrl", q, 32'h1);
        bus(0, `REG_FORMAT, 32'h0);
        check("format", q, 32'h0);
        bus(1, 7'h7F, 32'h5);
        bus(0, 7'h7F, 32'h0);
        check("unmapped", q, 32'h0);
        bus(1, 7'h30, 32'h1234);
        bus(1, 7'h20, 32'hA005);
        $display("test regs done");
    endtask
    task automatic t_frame();
        frame(16'hFF84, 16'hEC78, 1'b1);
        check("fwd", o_cmd_forward, 1'b1);
        check("en", o_cmd_enabled, 1'b1);
        check("ramp", {o_cmd_ramp_stop, o_cmd_coast_stop, o_cmd_reverse}, 3'h0);
        check("tgt", o_target_freq, 16'h09C4);
        check("tvalid", o_target_valid, 1'b1);
        for (int n = 0; n < 400 && wlog.size() < 10; n++) @(posedge i_clk);
        check("wr1", wlog[0], {16'h1234, words[2]});
        check("wr2", wlog[1], {16'h0000, words[3]});
        check("nwr", wlog.size(), 10);
        frame(16'h0088, 16'h0000, 1'b0);
        check("badfr", {o_cmd_forward, o_cmd_reverse, o_target_freq}, {2'b10, 16'h09C4});
        $display("test frame done");
    endtask
    task automatic t_abs();
        bus(1, `REG_FORMAT, 32'h1);
        frame(16'h00F3, 16'hF060, 1'b1);
        check("tgtabs", o_target_freq, 16'h0FA0);
        check("stops", {o_cmd_ramp_stop, o_cmd_coast_stop}, 2'h3);
        check("qt", {o_cmd_quick_stop, o_cmd_torque_mode, o_cmd_forward}, 3'h6);
        repeat (200) @(posedge i_clk);
        bus(1, `REG_CTRL, 32'h0);
        frame(16'h0080, 16'h0010, 1'b1);
        check("hold", {o_target_valid, o_target_freq}, {1'b0, 16'h0FA0});
        $display("test absolute done");
    endtask
    task automatic t_tx();
        txq.delete();
        i_tx_req <= 1'b1;
        @(posedge i_clk);
        i_tx_req <= 1'b0;
        repeat (18) @(posedge i_clk);
        check("ntx", txq.size(), 12);
        check("status", txq[0], 16'h000B);
        check("runf", txq[1], 16'h09C4);
        check("rdslot", txq[2], 16'h5FFA);
        $display("test return done");
    endtask
    task automatic t_leds();
        check("ledg", {o_ctrl_led_green, o_drv_led_green, o_drv_led_yellow}, 3'h6);
        i_master_lost <= 1'b1;
        i_drv_comm_ok <= 1'b0;
        i_config_err <= 1'b1;
        repeat (5) @(posedge i_clk);
        check("ledr", {o_ctrl_led_red, o_drv_led_red, o_ctrl_led_yellow}, 3'h6);
        i_master_lost <= 1'b0;
        repeat (5) @(posedge i_clk);
        check("ledy", o_ctrl_led_yellow, 1'b1);
        $display("test leds done");
    endtask
    initial begin
        {i_avs_read, i_avs_write, i_tx_req, go, i_drv_reverse, i_drv_fault, i_drv_coasting} = '0;
        {i_freq_reached, i_torque_active, i_config_err, i_master_lost, i_mac_bad} = '0;
        {i_drv_running, i_drv_forward, i_drv_comm_ok, i_master_found, good} = '1;
        i_avs_address = '0;
        i_avs_writedata = '0;
        i_run_freq = 16'h09C4;
        i_max_freq = 16'h1388;
        for (int i = 0; i < 12; i++) words[i] = 16'h0100 + 16'(i);
        i_reset = 1'b1;
        repeat (12) @(posedge i_clk);
        i_reset <= 1'b0;
        t_regs();
        t_frame();
        t_abs();
        t_tx();
        t_leds();
        conclude();
    end
endmodule
`default_nettype wire
